// file: verilog/i2c_slave_consts.svh
// constants of the two-wire register slave: addresses, framing, reset values
// assumes inclusion by the package and by the register interface module
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// ---------------------------------------------------------------
// clocks
// ---------------------------------------------------------------
`define MCLK_HZ          40000000
`define SCL_MAX_HZ       3400000
// fewest system clocks in one fastest bus clock period (rounded down)
`define SCL_MIN_CYCLES   (`MCLK_HZ / `SCL_MAX_HZ)

// ---------------------------------------------------------------
// slave addresses
// ---------------------------------------------------------------
`define ADDR_MAIN_HI     7'h48
`define ADDR_MAIN_LO     7'h40
// high-speed master code is 0000_1xxx
`define HS_CODE_PREFIX   5'h01

// ---------------------------------------------------------------
// byte framing
// ---------------------------------------------------------------
`define BIT_LAST         4'h7
`define CNT_BYTE_DONE    4'h8
`define CNT_ACK_DRIVE    4'h9
`define CNT_ACK_SAMPLED  4'ha

// ---------------------------------------------------------------
// register bank
// ---------------------------------------------------------------
`define REG_COUNT        16
`define REG_IDX_W        4
`define REG_RESET        8'h00
`define REG_EMPTY_READ   8'h00

`endif

// file: verilog/i2c_slave_pkg.sv
// types of the two-wire register slave
// assumes the constants header is on the include path
`include "i2c_slave_consts.svh"

package i2c_slave_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_RACK,
        ST_RLOAD
    } link_phase_t;

    typedef logic [`REG_COUNT-1:0][7:0] reg_bank_t;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } sync_state_t;

    typedef struct packed {
        logic data_bit;
        logic toggle;
    } link_state_t;

    typedef struct packed {
        link_phase_t phase;
        link_phase_t after_ack;
        logic [3:0]  cnt;
        logic [6:0]  shift;
        logic [7:0]  tx;
        logic [7:0]  ptr;
        logic        sda_low;
        logic        hs;
        logic        scl_prev;
        logic        sda_prev;
        logic        tog_prev;
        reg_bank_t   regs;
    } core_state_t;

endpackage

// file: verilog/level_sync.sv
// three-stage synchroniser with agreement filter for one asynchronous level
// assumes the destination clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module level_sync
    import i2c_slave_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    // destination clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level in and filtered level out
    input  wire logic d,
    output logic      q
);

    sync_state_t s_reg;
    sync_state_t s_next;

    // the output moves only once the second and third stages agree
    always_comb begin
        s_next       = s_reg;
        s_next.ff1   = d;
        s_next.ff2   = s_reg.ff1;
        s_next.ff3   = s_reg.ff2;
        if (s_reg.ff2 == s_reg.ff3) begin
            s_next.level = s_reg.ff3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{ff1: RESET_VAL, ff2: RESET_VAL, ff3: RESET_VAL, level: RESET_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.level;

endmodule // level_sync

`default_nettype wire

// file: verilog/i2c_slave_register_interface.sv
// two-wire slave giving an external master access to a bank of 8-bit registers
// assumes scl and sda_in come straight from the bus pads; sda is open drain
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_consts.svh"

module i2c_slave_register_interface
    import i2c_slave_pkg::*;
(
    // system clock and power-on reset
    input  wire logic  mclk,
    input  wire logic  reset_n,
    // interface supply and address strap
    input  wire logic  io_supply_ok,
    input  wire logic  addr_strap,
    // two-wire bus; scl is input only
    input  wire logic  scl,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe,
    // register contents and status
    output reg_bank_t  reg_bank,
    output logic       hs_filter_sel,
    output logic       addressed
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_pipe_reg;
    logic       rst_n_sync;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign rst_n_sync = rst_pipe_reg[1];

    // ---------------------------------------------------------------
    // link domain: bits are taken on the rising scl edge
    // ---------------------------------------------------------------
    link_state_t link_reg;
    link_state_t link_next;

    always_comb begin
        link_next          = link_reg;
        link_next.data_bit = sda_in;
        link_next.toggle   = ~link_reg.toggle;
    end

    always_ff @(posedge scl or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            link_reg <= '{data_bit: 1'b1, toggle: 1'b0};
        end else begin
            link_reg <= link_next;
        end
    end

    // ---------------------------------------------------------------
    // crossings into the system clock
    // ---------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic tog_s;
    logic io_ok_s;
    logic strap_s;

    level_sync #(.RESET_VAL(1'b1)) u_sync_scl (.clk(mclk), .rst_n(rst_n_sync),
        .d(scl), .q(scl_s));

    level_sync #(.RESET_VAL(1'b1)) u_sync_sda (.clk(mclk), .rst_n(rst_n_sync),
        .d(sda_in), .q(sda_s));

    level_sync #(.RESET_VAL(1'b0)) u_sync_tog (.clk(mclk), .rst_n(rst_n_sync),
        .d(link_reg.toggle), .q(tog_s));

    level_sync #(.RESET_VAL(1'b0)) u_sync_io (.clk(mclk), .rst_n(rst_n_sync),
        .d(io_supply_ok), .q(io_ok_s));

    level_sync #(.RESET_VAL(1'b0)) u_sync_strap (.clk(mclk), .rst_n(rst_n_sync),
        .d(addr_strap), .q(strap_s));

    // ---------------------------------------------------------------
    // bus events
    // ---------------------------------------------------------------
    core_state_t s_reg;
    core_state_t s_next;

    logic       start_ev;
    logic       stop_ev;
    logic       bit_ev;
    logic       scl_fall;
    logic       rx_bit;
    logic [7:0] rx_byte;
    logic [6:0] main_addr;
    logic       addr_match;
    logic       hs_code;
    logic [7:0] rd_data;
    logic       ptr_in_bank;

    // data bit is stable from its scl rise to the next one, long after the toggle lands
    assign rx_bit      = link_reg.data_bit;
    assign bit_ev      = tog_s ^ s_reg.tog_prev;
    assign scl_fall    = s_reg.scl_prev & ~scl_s;
    assign start_ev    = scl_s & s_reg.scl_prev & s_reg.sda_prev & ~sda_s;
    assign stop_ev     = scl_s & s_reg.scl_prev & ~s_reg.sda_prev & sda_s;
    assign rx_byte     = {s_reg.shift, rx_bit};
    assign main_addr   = strap_s ? `ADDR_MAIN_HI : `ADDR_MAIN_LO;
    assign addr_match  = (rx_byte[7:1] == main_addr);
    assign hs_code     = (rx_byte[7:3] == `HS_CODE_PREFIX);
    assign ptr_in_bank = (s_reg.ptr[7:`REG_IDX_W] == '0);
    assign rd_data     = ptr_in_bank ? s_reg.regs[s_reg.ptr[`REG_IDX_W-1:0]]
                                     : `REG_EMPTY_READ;

    // ---------------------------------------------------------------
    // protocol engine
    // ---------------------------------------------------------------
    localparam core_state_t CORE_RESET = '{
        phase:     ST_IDLE,
        after_ack: ST_IDLE,
        cnt:       4'h0,
        shift:     7'h00,
        tx:        8'h00,
        ptr:       8'h00,
        sda_low:   1'b0,
        hs:        1'b0,
        scl_prev:  1'b1,
        sda_prev:  1'b1,
        tog_prev:  1'b0,
        regs:      {`REG_COUNT{`REG_RESET}}
    };

    always_comb begin
        s_next          = s_reg;
        s_next.scl_prev = scl_s;
        s_next.sda_prev = sda_s;
        s_next.tog_prev = tog_s;
        if (!io_ok_s) begin
            // supply loss drops the transfer but keeps registers and pointer
            s_next.phase   = ST_IDLE;
            s_next.sda_low = 1'b0;
            s_next.hs      = 1'b0;
        end else if (start_ev) begin
            s_next.phase   = ST_ADDR;
            s_next.cnt     = 4'h0;
            s_next.sda_low = 1'b0;
        end else if (stop_ev) begin
            // pointer untouched; filters back to the slow setting
            s_next.phase   = ST_IDLE;
            s_next.sda_low = 1'b0;
            s_next.hs      = 1'b0;
        end else begin
            case (s_reg.phase)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (bit_ev) begin
                        s_next.shift = rx_byte[6:0];
                        s_next.cnt   = s_reg.cnt + 4'h1;
                        if (s_reg.cnt == `BIT_LAST) begin
                            s_next.cnt   = `CNT_BYTE_DONE;
                            s_next.phase = ST_ACK;
                            if (s_reg.phase == ST_ADDR) begin
                                if (addr_match) begin
                                    s_next.after_ack = rx_byte[0] ? ST_TX : ST_PTR;
                                end else begin
                                    s_next.phase = ST_IDLE;
                                    if (hs_code) begin
                                        s_next.hs = 1'b1;
                                    end
                                end
                            end else if (s_reg.phase == ST_PTR) begin
                                s_next.ptr       = rx_byte;
                                s_next.after_ack = ST_WDATA;
                            end else begin
                                if (ptr_in_bank) begin
                                    s_next.regs[s_reg.ptr[`REG_IDX_W-1:0]] = rx_byte;
                                end
                                s_next.ptr       = s_reg.ptr + 8'h01;
                                s_next.after_ack = ST_WDATA;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && s_reg.cnt == `CNT_BYTE_DONE) begin
                        s_next.sda_low = 1'b1;
                        s_next.cnt     = `CNT_ACK_DRIVE;
                    end else if (bit_ev && s_reg.cnt == `CNT_ACK_DRIVE) begin
                        s_next.cnt = `CNT_ACK_SAMPLED;
                    end else if (scl_fall && s_reg.cnt == `CNT_ACK_SAMPLED) begin
                        s_next.cnt     = 4'h0;
                        s_next.phase   = s_reg.after_ack;
                        s_next.sda_low = 1'b0;
                        if (s_reg.after_ack == ST_TX) begin
                            s_next.tx      = rd_data;
                            s_next.sda_low = ~rd_data[7];
                        end
                    end
                end
                ST_TX: begin
                    if (bit_ev) begin
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_reg.cnt == `CNT_BYTE_DONE) begin
                            s_next.sda_low = 1'b0;
                            s_next.phase   = ST_RACK;
                        end else begin
                            s_next.tx      = {s_reg.tx[6:0], 1'b0};
                            s_next.sda_low = ~s_reg.tx[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (bit_ev) begin
                        if (!rx_bit) begin
                            s_next.ptr   = s_reg.ptr + 8'h01;
                            s_next.phase = ST_RLOAD;
                        end else begin
                            s_next.phase = ST_IDLE;
                        end
                    end
                end
                ST_RLOAD: begin
                    if (scl_fall) begin
                        s_next.tx      = rd_data;
                        s_next.sda_low = ~rd_data[7];
                        s_next.cnt     = 4'h0;
                        s_next.phase   = ST_TX;
                    end
                end
                default: begin
                    s_next.sda_low = 1'b0;
                end
            endcase
        end
    end

    // registers clear only on the system power-on reset
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            s_reg <= CORE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs; scl is never driven, so the clock is never stretched
    // ---------------------------------------------------------------
    assign sda_out       = 1'b0;
    assign sda_oe        = s_reg.sda_low;
    assign reg_bank      = s_reg.regs;
    assign hs_filter_sel = s_reg.hs;
    assign addressed     = (s_reg.phase != ST_IDLE) && (s_reg.phase != ST_ADDR);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic byte_end;

    assign byte_end = bit_ev && !start_ev && !stop_ev && io_ok_s && (s_reg.cnt == `BIT_LAST);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_sync);

    a_sda_low_scl: assert property ($changed(sda_oe) && io_ok_s |-> !$past(scl_s))
        else $error("sda changed while scl was high");
    a_idle_released: assert property (s_reg.phase == ST_IDLE |-> !sda_oe)
        else $error("sda driven while idle");
    a_stop_keeps_ptr: assert property (stop_ev && io_ok_s |=> s_reg.ptr == $past(s_reg.ptr))
        else $error("stop changed the pointer");
    a_stop_slow_filter: assert property (stop_ev && io_ok_s |=> !hs_filter_sel)
        else $error("stop left high-speed filters");
    a_foreign_nack: assert property (s_reg.phase == ST_ADDR && byte_end && !addr_match
        |=> s_reg.phase == ST_IDLE && !sda_oe)
        else $error("foreign address not ignored");
    a_gencall_nack: assert property (s_reg.phase == ST_ADDR && bit_ev
        && rx_byte == 8'h00 && s_reg.cnt == `BIT_LAST |=> !sda_oe [*2])
        else $error("general call acknowledged");
    a_match_acks: assert property (s_reg.phase == ST_ADDR && byte_end && addr_match
        |=> s_reg.phase == ST_ACK)
        else $error("main address not taken");
    a_ptr_acked: assert property (s_reg.phase == ST_PTR && byte_end
        |=> s_reg.phase == ST_ACK && s_reg.ptr == $past(rx_byte))
        else $error("pointer byte not acknowledged");
    a_write_advance: assert property (s_reg.phase == ST_WDATA && byte_end
        |=> s_reg.ptr == $past(s_reg.ptr) + 8'h01)
        else $error("pointer not advanced after write");
    a_restart_addr: assert property (start_ev && io_ok_s
        |=> s_reg.phase == ST_ADDR && s_reg.cnt == 4'h0 && !sda_oe)
        else $error("start did not restart address reception");
    a_ack_held: assert property (s_reg.phase == ST_ACK
        && s_reg.cnt == `CNT_ACK_DRIVE |-> sda_oe)
        else $error("ack released early");

    c_write_byte: cover property (s_reg.phase == ST_WDATA && bit_ev && s_reg.cnt == `BIT_LAST);
    c_read_byte: cover property (s_reg.phase == ST_RACK && bit_ev);
    c_hs_entry: cover property ($rose(hs_filter_sel));
    c_foreign: cover property (s_reg.phase == ST_ADDR && bit_ev && s_reg.cnt == `BIT_LAST
        && !addr_match);

endmodule // i2c_slave_register_interface

`default_nettype wire

// file: verification/i2c_master_model.sv
// behavioural two-wire bus master driving the clock and pulling data low
// assumes an open-drain data wire with a pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    // master timing clock
    input  wire logic lclk,
    // resolved data wire
    input  wire logic sda_line,
    // bus clock and data pull-down
    output logic      scl,
    output logic      sda_low
);
    localparam int HALF = 25;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge lclk);
    endtask

    // ------------------------------------------------------------
    // frame conditions
    // ------------------------------------------------------------
    // also serves as repeated start from a low clock
    task automatic start();
        sda_low <= 1'b0;
        ticks(HALF);
        scl <= 1'b1;
        ticks(HALF);
        sda_low <= 1'b1;
        ticks(HALF);
        scl <= 1'b0;
        ticks(4);
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        ticks(HALF);
        scl <= 1'b1;
        ticks(HALF);
        sda_low <= 1'b0;
        ticks(HALF);
    endtask

    // ------------------------------------------------------------
    // bits and bytes
    // ------------------------------------------------------------
    // data changes only while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        sda_low <= !b;
        ticks(HALF);
        scl <= 1'b1;
        ticks(HALF);
        s = sda_line;
        scl <= 1'b0;
        ticks(4);
    endtask

    task automatic xfer(input logic [7:0] wb, input logic ack_in,
                        output logic [7:0] rb, output logic ack_out);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(wb[i], s);
            rb[i] = s;
        end
        clk_bit(ack_in, ack_out);
    endtask
endmodule // i2c_master_model

`default_nettype wire

// file: verification/i2c_slave_register_interface_tb.sv
// self-checking bench for the two-wire register slave
// assumes the master model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_register_interface_tb
    import i2c_slave_pkg::*;
;
    logic      mclk;
    logic      lclk;
    logic      reset_n;
    logic      io_supply_ok;
    logic      addr_strap;
    logic      scl;
    logic      m_low;
    logic      sda_out;
    logic      sda_oe;
    reg_bank_t reg_bank;
    logic      hs_filter_sel;
    logic      addressed;
    logic      scl_q;
    logic      oe_q;
    int        errors;
    int        n_compared;
    wire logic sda_line = !((sda_oe && !sda_out) || m_low);

    i2c_slave_register_interface dut (.mclk(mclk), .reset_n(reset_n),
        .io_supply_ok(io_supply_ok), .addr_strap(addr_strap), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .reg_bank(reg_bank),
        .hs_filter_sel(hs_filter_sel), .addressed(addressed));
    i2c_master_model m (.lclk(lclk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        lclk = 1'b0;
        #3.7;
        forever #6 lclk = ~lclk;
    end

    // ------------------------------------------------------------
    // shared checks and bus helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp, input string what);
        logic [7:0] rb;
        logic       ack;
        m.xfer(b, 1'b1, rb, ack);
        chk(what, {7'h00, exp}, {7'h00, ack});
    endtask

    task automatic recv(input logic mack, input logic [7:0] exp, input string what);
        logic [7:0] rb;
        logic       ack;
        m.xfer(8'hff, mack, rb, ack);
        chk(what, exp, rb);
    endtask

    task automatic settle();
        repeat (10) @(posedge mclk);
    endtask

    // pull-down may only move while the bus clock is low
    // sampled on the falling edge, where sda_oe has settled
    always @(negedge mclk) begin
        scl_q <= scl;
        oe_q <= sda_oe;
        if (reset_n && scl && scl_q && sda_oe !== oe_q) begin
            errors++;
            $display("Error sda_oe moved with scl high expected %b seen %b", oe_q, sda_oe);
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 16; i++) chk("reg after reset", 8'h00, reg_bank[i]);
        chk("sda_oe idle", 8'h00, {7'h00, sda_oe});
        chk("sda_out tied low", 8'h00, {7'h00, sda_out});
        chk("hs after reset", 8'h00, {7'h00, hs_filter_sel});
    endtask

    task automatic t_write();
        m.start();
        send(8'h90, 1'b0, "addr 48 write ack");
        chk("addressed", 8'h01, {7'h00, addressed});
        send(8'h0e, 1'b0, "pointer ack");
        send(8'ha5, 1'b0, "data 0 ack");
        send(8'h3c, 1'b0, "data 1 ack");
        send(8'h77, 1'b0, "absent register ack");
        m.stop();
        settle();
        chk("reg 14", 8'ha5, reg_bank[14]);
        chk("reg 15", 8'h3c, reg_bank[15]);
        chk("reg 0 untouched", 8'h00, reg_bank[0]);
        chk("addressed after stop", 8'h00, {7'h00, addressed});
    endtask

    task automatic t_read();
        m.start();
        send(8'h90, 1'b0, "addr write ack");
        send(8'h0e, 1'b0, "pointer ack");
        m.start();
        send(8'h91, 1'b0, "addr read after sr");
        recv(1'b0, 8'ha5, "read reg 14");
        recv(1'b1, 8'h3c, "read reg 15");
        m.stop();
        settle();
        m.start();
        send(8'h91, 1'b0, "addr read");
        recv(1'b1, 8'h3c, "pointer kept");
        m.stop();
        settle();
        m.start();
        send(8'h90, 1'b0, "addr write ack");
        send(8'h10, 1'b0, "pointer 16 ack");
        m.start();
        send(8'h91, 1'b0, "addr read after sr");
        recv(1'b1, 8'h00, "absent register read");
        m.stop();
        settle();
    endtask

    task automatic t_strap();
        @(negedge mclk);
        addr_strap = 1'b0;
        settle();
        m.start();
        send(8'h90, 1'b1, "foreign addr nack");
        send(8'h00, 1'b1, "ignored after mismatch");
        m.stop();
        m.start();
        send(8'h80, 1'b0, "addr 40 ack");
        send(8'h00, 1'b0, "pointer 0 ack");
        send(8'h5a, 1'b0, "data ack");
        m.stop();
        settle();
        chk("reg 0", 8'h5a, reg_bank[0]);
        m.start();
        send(8'h00, 1'b1, "general call nack");
        m.stop();
        @(negedge mclk);
        addr_strap = 1'b1;
        settle();
    endtask

    task automatic t_hs();
        m.start();
        send(8'h08, 1'b1, "master code nack");
        settle();
        chk("hs filters on", 8'h01, {7'h00, hs_filter_sel});
        m.stop();
        settle();
        chk("hs filters off", 8'h00, {7'h00, hs_filter_sel});
    endtask

    task automatic t_supply();
        @(negedge mclk);
        io_supply_ok = 1'b0;
        settle();
        chk("reg kept", 8'ha5, reg_bank[14]);
        chk("sda released", 8'h00, {7'h00, sda_oe});
        @(negedge mclk);
        io_supply_ok = 1'b1;
        settle();
        chk("reg kept after", 8'h5a, reg_bank[0]);
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        settle();
        chk("reg cleared", 8'h00, reg_bank[14]);
    endtask

    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    task automatic test_done();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        $display("Error run length expected finish seen timeout");
        test_done();
    end

    initial begin
        errors = 0;
        n_compared = 0;
        reset_n = 1'b0;
        io_supply_ok = 1'b1;
        addr_strap = 1'b1;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        settle();
        t_reset();
        t_write();
        t_read();
        t_strap();
        t_hs();
        t_supply();
        test_done();
    end
endmodule // i2c_slave_register_interface_tb

`default_nettype wire
